// ===== common/i2srp_cfg.svh
// Constants of the two-wire slave register port
`ifndef I2SRP_CFG_SVH
`define I2SRP_CFG_SVH

// Fixed bus address of the slave, seven bits
`define I2SRP_SLV_ADDR 7'h68
// Direction bit value that asks for a read
`define I2SRP_DIR_READ 1'b1
// Bits in one byte, counted by the bit counter
`define I2SRP_BYTE_BITS 4'h8
// Register pointer value after reset
`define I2SRP_PTR_RST 8'h00
// Last pointer value of the seconds counter window
`define I2SRP_TOD_LAST 8'h03
// Bus clock rates the port must follow, in kHz
`define I2SRP_STD_KHZ 100
`define I2SRP_FAST_KHZ 400
// Link sampling clock period, in ns
`define I2SRP_LCLK_NS 15
// Link clock cycles in the shortest fast-mode half period, rounded down
`define I2SRP_HALF_CYC ((1000000 / (2 * `I2SRP_FAST_KHZ)) / `I2SRP_LCLK_NS)

`endif

// ===== common/i2srp_pkg.sv
// Types shared by the two-wire slave register port
package i2srp_pkg;

    // Kinds of request that the link side sends to the register side
    typedef enum logic [1:0] {
        I2SRP_REQ_PTR,
        I2SRP_REQ_WR,
        I2SRP_REQ_RD_FIRST,
        I2SRP_REQ_RD_NEXT
    } i2srp_req_kind_t;

    // One request word crossing from the link to the register side
    typedef struct packed {
        i2srp_req_kind_t kind;
        logic [7:0] data;
    } i2srp_req_t;

    // Link engine states
    typedef enum logic [2:0] {
        I2SRP_ST_IDLE,
        I2SRP_ST_ADDR,
        I2SRP_ST_WORD,
        I2SRP_ST_WDATA,
        I2SRP_ST_RDATA,
        I2SRP_ST_IGNORE
    } i2srp_state_t;

endpackage

// ===== dv/i2srp_master.sv
// Bus master model that drives clock and data of the two-wire link
`timescale 1ns/1ps

module i2srp_master (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // Low and high clock periods in ns, fast mode by default
    int tl = 1300;
    int th = 1200;

    // Idle bus: both lines released high, clock still between frames
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Start or repeated start: data falls while clock is high
    task automatic start();
        #100;
        o_sda_low = 1'b0;
        #(tl - 100);
        o_scl = 1'b1;
        #(th / 2);
        o_sda_low = 1'b1;
        #(th / 2);
        o_scl = 1'b0;
    endtask

    // Stop: data rises while clock is high, then the bus rests
    task automatic stop();
        #100;
        o_sda_low = 1'b1;
        #(tl - 100);
        o_scl = 1'b1;
        #(th / 2);
        o_sda_low = 1'b0;
        #(tl);
    endtask

    // One clock pulse; data moves only well after the clock fall
    task automatic bit_cycle(input logic v, output logic s);
        #100;
        o_sda_low = ~v;
        #(tl - 100);
        o_scl = 1'b1;
        #(th / 2);
        s = i_sda;
        #(th / 2);
        o_scl = 1'b0;
    endtask

    // Eight bits out, most significant first, then the ninth clock
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // Eight bits in, then acknowledge, or withhold it on the last byte
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(nack, s);
    endtask
endmodule

// ===== dv/i2srp_top_test.sv
// Testbench of the two-wire slave register port
`timescale 1ns/1ps

module i2srp_top_test;
    logic i_mclk;
    logic i_lclk;
    logic i_reset;
    logic i_ce;
    logic [31:0] i_tod;
    logic o_sda;
    logic o_sda_oe;
    logic [7:0] o_reg_ptr;
    logic [7:0] o_reg_wdata;
    logic o_reg_wstb;
    logic o_reg_rstb;
    logic [7:0] mem [0:255];
    wire logic scl;
    wire logic sda_low;
    wire logic sda;
    wire logic [7:0] i_reg_rdata;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wr_count = 0;

    // Open-drain wire with pull-up; released means high
    assign sda = ((o_sda_oe && !o_sda) || sda_low) ? 1'b0 : 1'b1;
    assign i_reg_rdata = mem[o_reg_ptr];

    i2srp_top DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_lclk(i_lclk),
        .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
        .i_reg_rdata(i_reg_rdata), .i_tod(i_tod), .o_reg_ptr(o_reg_ptr),
        .o_reg_wdata(o_reg_wdata), .o_reg_wstb(o_reg_wstb), .o_reg_rstb(o_reg_rstb));

    i2srp_master mst (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    // Two unrelated clocks
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        i_lclk = 1'b0;
        #4.1;
        forever #7.5 i_lclk = ~i_lclk;
    end

    // Seconds counter with all four bytes equal, so a torn read shows
    always @(negedge i_mclk) begin
        i_tod <= {4{i_tod[7:0] + 8'h01}};
    end

    // Register bank: the strobe stores at the pointer of the cycle before
    always @(posedge i_mclk) begin
        cycles++;
        if (o_reg_wstb === 1'b1) begin
            mem[o_reg_ptr - 8'h01] <= o_reg_wdata;
            wr_count++;
        end
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic ack_exp);
        logic a;
        mst.wbyte(b, a);
        check("ack bit", {31'h0, a}, {31'h0, ack_exp});
    endtask

    task automatic recv(input logic nack, input logic [7:0] exp);
        logic [7:0] b;
        mst.rbyte(nack, b);
        check("read byte", {24'h0, b}, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (12) @(negedge i_mclk);
    endtask

    // Write across the pointer wrap, then read back after a repeated start
    task automatic t_write_read();
        mst.start();
        send(8'hd0, 1'b1);
        send(8'hfd, 1'b1);
        send(8'ha5, 1'b1);
        send(8'h5a, 1'b1);
        send(8'h3c, 1'b1);
        mst.start();
        send(8'hd0, 1'b1);
        send(8'hfd, 1'b1);
        mst.start();
        send(8'hd1, 1'b1);
        recv(1'b0, 8'ha5);
        recv(1'b0, 8'h5a);
        recv(1'b1, 8'h3c);
        #300;
        check("release after nack", {31'h0, o_sda_oe}, 32'h0);
        mst.stop();
        settle();
        check("write count", wr_count, 3);
        check("pointer", {24'h0, o_reg_ptr}, 32'h00);
    endtask

    // Read without a pointer write, at the standard clock rate
    task automatic t_no_ptr();
        mst.tl = 4700;
        mst.th = 4300;
        mst.start();
        send(8'hd1, 1'b1);
        recv(1'b1, 8'h7a);
        mst.stop();
        mst.tl = 1300;
        mst.th = 1200;
        settle();
        check("pointer", {24'h0, o_reg_ptr}, 32'h21);
    endtask

    // Foreign address: no answer, the rest of the frame is ignored
    task automatic t_bad_addr();
        mst.start();
        send(8'ha0, 1'b0);
        send(8'hd0, 1'b0);
        mst.stop();
        settle();
        check("write count", wr_count, 3);
        check("pointer", {24'h0, o_reg_ptr}, 32'h21);
    endtask

    // Stop after half a data byte must not store it
    task automatic t_abort();
        logic s;
        mst.start();
        send(8'hd0, 1'b1);
        send(8'h20, 1'b1);
        for (int i = 0; i < 4; i++) begin
            mst.bit_cycle(1'b0, s);
        end
        mst.stop();
        settle();
        check("write count", wr_count, 3);
        check("untouched byte", {24'h0, mem[8'h20]}, 32'h7a);
        check("pointer", {24'h0, o_reg_ptr}, 32'h20);
    endtask

    // Seconds counter read comes from one snapshot
    task automatic t_tod();
        logic [7:0] b [0:3];
        mst.start();
        send(8'hd0, 1'b1);
        send(8'h00, 1'b1);
        mst.start();
        send(8'hd1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            mst.rbyte(i == 3, b[i]);
        end
        mst.stop();
        settle();
        check("seconds bytes", {b[1], b[2], b[3]}, {3{b[0]}});
        check("pointer", {24'h0, o_reg_ptr}, 32'h04);
    endtask

    // Main sequence
    initial begin
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_tod = 32'h0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
        repeat (6) @(negedge i_mclk);
        check("reset outputs", {o_sda_oe, o_reg_wstb, o_reg_rstb, o_reg_ptr, o_reg_wdata},
            32'h0);
        i_reset = 1'b0;
        settle();
        t_write_read();
        t_abort();
        t_no_ptr();
        t_bad_addr();
        t_tod();
        end_sim();
    end
endmodule

// ===== hdl/i2srp_top.sv
// Two-wire slave register port: bus engine on the link clock, pointer on the main clock
//
// Behaviour
// - Slave only; works at 100 kHz and 400 kHz bus clocks.
// - SDA falling while SCL high is START, begins a transfer.
// - SDA rising while SCL high is STOP, ends a transfer.
// - SDA changes only while SCL low; one SCL pulse per bit.
// - Bytes of eight bits, then a ninth acknowledge clock.
// - Any number of data bytes between START and STOP.
// - Acknowledger holds SDA low over the whole ninth-clock high period.
// - Master withholds acknowledge on last read byte; device releases SDA.
// - First byte compared to fixed 7-bit address; acknowledge on match.
// - Write direction: next byte loads the register pointer, acknowledged.
// - Further write bytes stored at pointer, acknowledged, pointer advanced.
// - Read direction: bytes sent from current pointer, pointer advanced each byte.
// - Pointer persists between transfers.
// - Read continues while master acknowledges; ends on not-acknowledge, STOP or repeated START.
// - Repeated START ends transfer and starts address reception again.
// - Open-drain SDA: device only pulls low or releases.
// - Reading seconds counter bytes 0 to 3 returns a captured snapshot.
`timescale 1ns/1ps
`include "i2srp_cfg.svh"

module i2srp_top (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_lclk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic [7:0] i_reg_rdata,
    input wire logic [31:0] i_tod,
    output logic [7:0] o_reg_ptr,
    output logic [7:0] o_reg_wdata,
    output logic o_reg_wstb,
    output logic o_reg_rstb
);
    import i2srp_pkg::*;

    // ****************************************************
    // Link domain: reset release, pin sampling, conditions
    // ****************************************************

    logic [1:0] lrst_ff;
    logic lrst;
    logic scl_m_ff, scl_s_ff, scl_q_ff;
    logic sda_m_ff, sda_s_ff, sda_q_ff;
    logic scl_rise, scl_fall, start_det, stop_det;

    // Reset leaves the link domain only on its own clock edge
    always_ff @(posedge i_lclk or posedge i_reset) begin
        if (i_reset) begin
            lrst_ff <= 2'h3;
        end else begin
            lrst_ff <= {lrst_ff[0], 1'b0};
        end
    end
    assign lrst = lrst_ff[1];

    // Pins are foreign to every clock here, so two flops come first
    always_ff @(posedge i_lclk or posedge lrst) begin
        if (lrst) begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            scl_q_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_m_ff <= i_scl;
            scl_s_ff <= scl_m_ff;
            scl_q_ff <= scl_s_ff;
            sda_m_ff <= i_sda;
            sda_s_ff <= sda_m_ff;
            sda_q_ff <= sda_s_ff;
        end
    end

    // Edges and bus conditions; sampling at 15 ns covers fast mode easily
    assign scl_rise = scl_s_ff & ~scl_q_ff;
    assign scl_fall = ~scl_s_ff & scl_q_ff;
    assign start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
    assign stop_det = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;

    // ****************************************************
    // Link domain: byte engine
    // ****************************************************

    i2srp_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic ack_ph_ff, nxt_ack_ph;
    logic [7:0] rx_ff, nxt_rx;
    logic [7:0] tx_ff, nxt_tx;
    logic sda_oe_ff, nxt_sda_oe;
    logic sda_out_ff;
    logic req_tgl_ff, nxt_req_tgl;
    i2srp_req_t req_ff, nxt_req;
    logic rsp_m_ff, rsp_s_ff, rsp_q_ff;
    logic [7:0] tx_next_ff;
    logic rsp_seen;
    // Read answer from the main domain, declared here as the link side samples it
    logic rsp_tgl_ff;
    logic [7:0] rsp_data_ff, nxt_rsp;
    logic byte_end, ack_end, recv_st, addr_hit, is_read;

    assign byte_end = scl_fall && (cnt_ff == `I2SRP_BYTE_BITS) && !ack_ph_ff;
    assign ack_end = scl_fall && ack_ph_ff;
    assign recv_st = (state_ff == I2SRP_ST_ADDR) || (state_ff == I2SRP_ST_WORD)
                     || (state_ff == I2SRP_ST_WDATA);
    assign addr_hit = (rx_ff[7:1] == `I2SRP_SLV_ADDR);
    assign is_read = (rx_ff[0] == `I2SRP_DIR_READ);

    // Next-state logic; SDA moves only on a detected SCL fall
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ack_ph = ack_ph_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_req_tgl = req_tgl_ff;
        nxt_req = req_ff;
        if (start_det) begin
            // Also a repeated START: no write, straight to address
            nxt_state = I2SRP_ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_ack_ph = 1'b0;
            nxt_sda_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state = I2SRP_ST_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (state_ff == I2SRP_ST_IDLE || state_ff == I2SRP_ST_IGNORE) begin
            nxt_sda_oe = 1'b0;
        end else if (recv_st) begin
            if (scl_rise && !ack_ph_ff && cnt_ff != `I2SRP_BYTE_BITS) begin
                nxt_rx = {rx_ff[6:0], sda_s_ff};
                nxt_cnt = cnt_ff + 4'h1;
            end else if (byte_end) begin
                nxt_ack_ph = 1'b1;
                nxt_sda_oe = 1'b1; // Pull low for the ninth clock
                nxt_req.data = rx_ff;
                if (state_ff == I2SRP_ST_ADDR) begin
                    if (!addr_hit) begin
                        nxt_state = I2SRP_ST_IGNORE;
                        nxt_sda_oe = 1'b0;
                        nxt_ack_ph = 1'b0;
                    end else if (is_read) begin
                        nxt_state = I2SRP_ST_RDATA;
                        nxt_req.kind = I2SRP_REQ_RD_FIRST;
                        nxt_req_tgl = ~req_tgl_ff;
                    end else begin
                        nxt_state = I2SRP_ST_WORD;
                    end
                end else if (state_ff == I2SRP_ST_WORD) begin
                    nxt_state = I2SRP_ST_WDATA;
                    nxt_req.kind = I2SRP_REQ_PTR;
                    nxt_req_tgl = ~req_tgl_ff;
                end else begin
                    nxt_req.kind = I2SRP_REQ_WR; // Unlimited count
                    nxt_req_tgl = ~req_tgl_ff;
                end
            end else if (ack_end) begin
                nxt_ack_ph = 1'b0;
                nxt_cnt = 4'h0;
                nxt_sda_oe = 1'b0;
                if (state_ff == I2SRP_ST_RDATA) begin
                    nxt_tx = tx_next_ff;
                    nxt_sda_oe = ~tx_next_ff[7]; // First bit of the read
                end
            end
        end else begin
            // Transmitting; open drain, so a one is a released line
            if (scl_rise && !ack_ph_ff && cnt_ff != `I2SRP_BYTE_BITS) begin
                nxt_cnt = cnt_ff + 4'h1;
            end else if (scl_fall && !ack_ph_ff && cnt_ff != 4'h0
                         && cnt_ff != `I2SRP_BYTE_BITS) begin
                nxt_tx = {tx_ff[6:0], 1'b0};
                nxt_sda_oe = ~tx_ff[6];
            end else if (byte_end) begin
                nxt_ack_ph = 1'b1;
                nxt_sda_oe = 1'b0; // Master answers in the ninth clock
            end else if (scl_rise && ack_ph_ff && !sda_oe_ff) begin
                // Own address acknowledge is not a master answer, so skip it
                if (sda_s_ff) begin
                    nxt_state = I2SRP_ST_IGNORE; // Not-acknowledge ends it
                end else begin
                    nxt_req.kind = I2SRP_REQ_RD_NEXT;
                    nxt_req_tgl = ~req_tgl_ff;
                end
            end else if (ack_end) begin
                nxt_ack_ph = 1'b0;
                nxt_cnt = 4'h0;
                nxt_tx = tx_next_ff;
                nxt_sda_oe = ~tx_next_ff[7];
            end
        end
    end

    // Engine registers
    always_ff @(posedge i_lclk or posedge lrst) begin
        if (lrst) begin
            state_ff <= I2SRP_ST_IDLE;
            cnt_ff <= 4'h0;
            ack_ph_ff <= 1'b0;
            rx_ff <= 8'h00;
            tx_ff <= 8'hff;
            sda_oe_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ack_ph_ff <= nxt_ack_ph;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            sda_oe_ff <= nxt_sda_oe;
            req_tgl_ff <= nxt_req_tgl;
            req_ff <= nxt_req;
        end
    end

    // The line level is only ever low; the device never drives high
    always_ff @(posedge i_lclk or posedge lrst) begin
        if (lrst) begin
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
        end
    end

    // Read answer crossing in: toggle synchronised, byte held stable by sender
    assign rsp_seen = rsp_s_ff ^ rsp_q_ff;
    always_ff @(posedge i_lclk or posedge lrst) begin
        if (lrst) begin
            rsp_m_ff <= 1'b0;
            rsp_s_ff <= 1'b0;
            rsp_q_ff <= 1'b0;
            tx_next_ff <= 8'hff;
        end else begin
            rsp_m_ff <= rsp_tgl_ff;
            rsp_s_ff <= rsp_m_ff;
            rsp_q_ff <= rsp_s_ff;
            if (rsp_seen) begin
                tx_next_ff <= rsp_data_ff;
            end
        end
    end

    assign o_sda = sda_out_ff;
    assign o_sda_oe = sda_oe_ff;

    // ****************************************************
    // Main domain: pointer, strobes and seconds snapshot
    // ****************************************************

    logic req_m_ff, req_s_ff, req_q_ff;
    logic req_seen, is_rd, in_tod, live_tod;
    logic [7:0] ptr_ff, nxt_ptr;
    logic [7:0] wdata_ff;
    logic wstb_ff, rstb_ff;
    logic [31:0] snap_ff;

    // Byte lane of the seconds word; pointer 0 is the low byte
    function automatic logic [7:0] tod_byte(input logic [31:0] w, input logic [1:0] idx);
        tod_byte = w[8 * idx +: 8];
    endfunction

    // Request word is stable long before its toggle arrives here
    assign req_seen = req_s_ff ^ req_q_ff;
    assign is_rd = (req_ff.kind == I2SRP_REQ_RD_FIRST) || (req_ff.kind == I2SRP_REQ_RD_NEXT);
    assign in_tod = (ptr_ff <= `I2SRP_TOD_LAST);
    assign live_tod = in_tod && (req_ff.kind == I2SRP_REQ_RD_FIRST);
    assign nxt_ptr = !req_seen ? ptr_ff :
                     (req_ff.kind == I2SRP_REQ_PTR) ? req_ff.data : ptr_ff + 8'h01;
    assign nxt_rsp = !in_tod ? i_reg_rdata :
                     live_tod ? tod_byte(i_tod, ptr_ff[1:0]) :
                     tod_byte(snap_ff, ptr_ff[1:0]);

    // Toggle synchroniser for requests; i_ce freezes this domain
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            req_m_ff <= 1'b0;
            req_s_ff <= 1'b0;
            req_q_ff <= 1'b0;
        end else if (i_ce) begin
            req_m_ff <= req_tgl_ff;
            req_s_ff <= req_m_ff;
            req_q_ff <= req_s_ff;
        end
    end

    // Pointer only moves on requests, so it outlives every transfer
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ptr_ff <= `I2SRP_PTR_RST;
            wdata_ff <= 8'h00;
            wstb_ff <= 1'b0;
            rstb_ff <= 1'b0;
        end else if (i_ce) begin
            ptr_ff <= nxt_ptr;
            wstb_ff <= req_seen && (req_ff.kind == I2SRP_REQ_WR);
            rstb_ff <= req_seen && is_rd;
            if (req_seen) begin
                wdata_ff <= req_ff.data;
            end
        end
    end

    // Snapshot on the first read byte; the live counter keeps running outside
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            snap_ff <= 32'h0000_0000;
            rsp_tgl_ff <= 1'b0;
            rsp_data_ff <= 8'hff;
        end else if (i_ce && req_seen && is_rd) begin
            if (live_tod) begin
                snap_ff <= i_tod;
            end
            rsp_data_ff <= nxt_rsp;
            rsp_tgl_ff <= ~rsp_tgl_ff;
        end
    end

    assign o_reg_ptr = ptr_ff;
    assign o_reg_wdata = wdata_ff;
    assign o_reg_wstb = wstb_ff;
    assign o_reg_rstb = rstb_ff;

    // ****************************************************
    // Checks
    // ****************************************************

    chk_sda_low_only: assert property (@(posedge i_lclk) disable iff (lrst)
        o_sda == 1'b0) else $error("SDA driven high");

    chk_start_to_addr: assert property (@(posedge i_lclk) disable iff (lrst)
        start_det |=> state_ff == I2SRP_ST_ADDR && !sda_oe_ff && cnt_ff == 4'h0)
        else $error("START did not restart address reception");

    chk_stop_to_idle: assert property (@(posedge i_lclk) disable iff (lrst)
        stop_det |=> state_ff == I2SRP_ST_IDLE && !sda_oe_ff)
        else $error("STOP did not free the port");

    chk_sda_scl_low: assert property (@(posedge i_lclk) disable iff (lrst)
        $rose(sda_oe_ff) |-> !scl_s_ff && $past(scl_fall))
        else $error("SDA pulled outside SCL low");

    chk_addr_ack_hold: assert property (@(posedge i_lclk) disable iff (lrst)
        byte_end && state_ff == I2SRP_ST_ADDR && addr_hit && !start_det && !stop_det
        |=> sda_oe_ff until_with ack_end) else $error("Address acknowledge dropped");

    chk_ack_bounded: assert property (@(posedge i_lclk) disable iff (lrst)
        $rose(ack_ph_ff) && sda_oe_ff |-> ##[1:1000] (!ack_ph_ff || !sda_oe_ff))
        else $error("Acknowledge never ended");

    chk_miss_ignore: assert property (@(posedge i_lclk) disable iff (lrst)
        byte_end && state_ff == I2SRP_ST_ADDR && !addr_hit && !start_det && !stop_det
        |=> state_ff == I2SRP_ST_IGNORE && !sda_oe_ff)
        else $error("Foreign address not ignored");

    chk_nack_release: assert property (@(posedge i_lclk) disable iff (lrst)
        scl_rise && ack_ph_ff && state_ff == I2SRP_ST_RDATA && sda_s_ff && !stop_det
        |=> state_ff == I2SRP_ST_IGNORE ##1 !sda_oe_ff)
        else $error("SDA held after not-acknowledge");

    chk_ptr_load: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_ce && req_seen && req_ff.kind == I2SRP_REQ_PTR |=> ptr_ff == $past(req_ff.data))
        else $error("Pointer not loaded");

    chk_write_step: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_ce && req_seen && req_ff.kind == I2SRP_REQ_WR
        |=> o_reg_wstb && ptr_ff == 8'($past(ptr_ff) + 8'h01))
        else $error("Write did not strobe and advance");

    chk_ptr_keeps: assert property (@(posedge i_mclk) disable iff (i_reset)
        !(i_ce && req_seen) |=> $stable(ptr_ff)) else $error("Pointer moved unasked");

    chk_tod_snap: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_ce && req_seen && live_tod |=> snap_ff == $past(i_tod))
        else $error("Seconds snapshot missed");

    cov_write_ack: cover property (@(posedge i_lclk) disable iff (lrst)
        byte_end && state_ff == I2SRP_ST_WDATA);
    cov_read_nack: cover property (@(posedge i_lclk) disable iff (lrst)
        scl_rise && ack_ph_ff && state_ff == I2SRP_ST_RDATA && sda_s_ff);
    cov_rep_start: cover property (@(posedge i_lclk) disable iff (lrst)
        start_det && state_ff == I2SRP_ST_WDATA);
    cov_tod_read: cover property (@(posedge i_mclk) disable iff (i_reset)
        i_ce && req_seen && live_tod);

endmodule
